//--- dv/test_adc_core_power_timing_ctrl.sv
// Purpose: Self-checking bench of the converter core power and timing controller
// Assumes: Zero-wait-state slave, source divider 0
// Notes: Reads are checked from a queue by a monitor
`timescale 1ns/1ps
`include "adcpt_defines.svh"
module test_adc_core_power_timing_ctrl;
  import adcpt_pkg::*;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, bufRead = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, coreTrigger = 0, twoEndedMode = 0, negInputActive, coreSampling;
  logic [1:0] coreConvStart, coreDataReady;
  logic [2:0] hsize = 0, corePowerOn;
  logic [3:0] bufReadChan = 0, core0InputOneHot, core1InputOneHot;
  logic [14:0] earlyIrqFlag;
  logic commonIrq, earlyIrq, rdPhase = 0;
  logic [31:0] expQ[$];
  logic [31:0] r = 32'd70013;
  int errors = 0, total_checks = 0, n, m;
  always #5 clk = ~clk;
  adcpt_ctrl adcpt_ctrl_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .coreTrigger(coreTrigger),
    .twoEndedMode(twoEndedMode), .bufRead(bufRead), .bufReadChan(bufReadChan),
    .core0InputOneHot(core0InputOneHot), .core1InputOneHot(core1InputOneHot),
    .negInputActive(negInputActive), .corePowerOn(corePowerOn), .coreSampling(coreSampling),
    .coreConvStart(coreConvStart), .coreDataReady(coreDataReady),
    .earlyIrqFlag(earlyIrqFlag), .commonIrq(commonIrq), .earlyIrq(earlyIrq));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("Error at %0t: value mismatch", $time);
    end
  endtask : chk
  task automatic hang();
    errors++;
    $display("Error at %0t: wait timed out", $time);
    tally_and_finish();
  endtask : hang
  // Read data phase compare
  always @(posedge clk)
  begin
    if (rdPhase && hreadyout === 1'b1)
    begin
      chk(expQ.size() > 0 && hrdata === expQ.pop_front());
      chk(hresp === 1'b0);
    end
    rdPhase <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    if (!w)
      expQ.push_back(d);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk);
      n = 0;
      while (hreadyout !== 1'b1)
      begin
        if (++n > 50)
          hang();
        @(posedge clk);
      end
      if (k == 0)
      begin
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
      end
    end
  endtask : bus
  // Cycles until a watched output is high
  task automatic waitFor(input int s, output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      if (++c > 200)
        hang();
    end
    while (!(s == 0 ? commonIrq : s == 1 ? coreConvStart[0] : s == 2 ? coreDataReady[0]
      : earlyIrq));
  endtask : waitFor
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(0, `ADCPT_OFF_INSEL, 0);
    bus(0, `ADCPT_OFF_PWR, 0);
    bus(0, `ADCPT_OFF_CLK0, 32'h300);
    bus(0, 8'hfc, 0);
    r = lfsr(r);
    bus(1, `ADCPT_OFF_INSEL, r);
    bus(0, `ADCPT_OFF_INSEL, r & 32'hf);
    for (int c = 0; c < 16; c++)
    begin
      bus(1, `ADCPT_OFF_INSEL, c);
      repeat (2) @(posedge clk);
      chk(core0InputOneHot === 4'h1 << c[1:0]);
      chk(core1InputOneHot === 4'h1 << c[3:2]);
      twoEndedMode <= c[1:0];
      repeat (3) @(posedge clk);
      chk(negInputActive === c[1:0]);
    end
    for (int i = 0; i < 2; i++)
    begin
      bus(0, i ? `ADCPT_OFF_EARLY_IRQ_ENABLE : `ADCPT_OFF_LVL, 0);
      bus(1, i ? `ADCPT_OFF_EARLY_IRQ_ENABLE : `ADCPT_OFF_LVL, 32'hffff);
      bus(0, i ? `ADCPT_OFF_EARLY_IRQ_ENABLE : `ADCPT_OFF_LVL, 32'h4fff);
      bus(1, i ? `ADCPT_OFF_EARLY_IRQ_ENABLE : `ADCPT_OFF_LVL, i);
    end
    bus(1, `ADCPT_OFF_SRCDIV, 0);
    bus(1, `ADCPT_OFF_WARM, 32'h483);
    bus(1, `ADCPT_OFF_PWR, 32'h83);
    waitFor(0, n);
    chk(n >= 14 && n <= 20);
    chk(corePowerOn === 3'b111);
    bus(0, `ADCPT_OFF_PWR, 32'h8383);
    bus(1, `ADCPT_OFF_PWR, 0);
    bus(0, `ADCPT_OFF_PWR, 0);
    bus(1, `ADCPT_OFF_WARM, 32'h500);
    bus(1, `ADCPT_OFF_PWR, 32'h83);
    m = 0;
    repeat (20)
    begin
      @(posedge clk);
      m += commonIrq;
    end
    bus(0, `ADCPT_OFF_PWR, 32'h83);
    repeat (20)
    begin
      @(posedge clk);
      m += commonIrq;
    end
    chk(m == 0);
    bus(0, `ADCPT_OFF_PWR, 32'h8383);
    bus(1, `ADCPT_OFF_INSEL, 0);
    bus(1, `ADCPT_OFF_CLK0, 32'h1);
    chk(coreSampling === 2'b11);
    coreTrigger <= 2'b01;
    waitFor(1, n);
    chk(n >= 1 && n <= 4);
    waitFor(3, n);
    chk(n >= 12 && n <= 16);
    chk(coreSampling === 2'b10);
    waitFor(2, n);
    chk(n >= 1 && n <= 3);
    chk(earlyIrqFlag === 15'h1);
    bufRead <= 1;
    @(posedge clk);
    bufRead <= 0;
    repeat (2) @(posedge clk);
    chk(earlyIrqFlag === 15'h0);
    coreTrigger <= 2'b00;
    bus(1, `ADCPT_OFF_DLY0, 32'h1);
    bus(1, `ADCPT_OFF_DLYEN, 32'h1);
    coreTrigger <= 2'b01;
    waitFor(1, n);
    chk(n >= 6 && n <= 10);
    repeat (40) @(posedge clk);
    tally_and_finish();
  end
endmodule : test_adc_core_power_timing_ctrl

//--- include/adcpt_core_if.sv
// Purpose: Configuration and status between controller and core sequencer
// Assumes: One clock domain
// Notes: Pulses last one clock
`timescale 1ns/1ps
interface adcpt_core_if;
  logic trigger;
  logic ready;
  logic levelMode;
  logic delayEn;
  logic [9:0] delay;
  logic [6:0] source_clock_divider;
  logic [1:0] bitDepth;
  logic [2:0] early_irq_lead_select;
  logic sampling;
  logic convStart;
  logic dataReady;
  logic early;
  modport ctrl (output trigger, ready, levelMode, delayEn, delay, source_clock_divider, bitDepth, early_irq_lead_select,
    input sampling, convStart, dataReady, early);
  modport seq (input trigger, ready, levelMode, delayEn, delay, source_clock_divider, bitDepth, early_irq_lead_select,
    output sampling, convStart, dataReady, early);
endinterface : adcpt_core_if

//--- include/adcpt_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          converter core power and timing controller
// Assumes: Word-aligned byte addresses, low eight address bits decoded
// Notes: Definitions only
`ifndef ADCPT_DEFINES_SVH
`define ADCPT_DEFINES_SVH

`define ADCPT_OFF_INSEL 8'h00
`define ADCPT_OFF_PWR 8'h04
`define ADCPT_OFF_WARM 8'h08
`define ADCPT_OFF_DLY0 8'h0c
`define ADCPT_OFF_CLK0 8'h10
`define ADCPT_CORE_STRIDE 8'h08
`define ADCPT_OFF_DLYEN 8'h1c
`define ADCPT_OFF_LVL 8'h20
`define ADCPT_OFF_EARLY_IRQ_ENABLE 8'h24
`define ADCPT_OFF_EIFLAG 8'h28
`define ADCPT_OFF_SRCDIV 8'h2c

`define ADCPT_CHAN_MASK 15'h4fff
`define ADCPT_NO_CHAN 4'hf
`define ADCPT_RES_RESET 2'h3
`define ADCPT_SHR_PWR_BIT 7
`define ADCPT_SHR_RDY_BIT 15
`define ADCPT_RDY_LSB 8
`define ADCPT_WARM_LSB 8
`define ADCPT_EARLY_IRQ_LEAD_SELECT_LSB 10
`define ADCPT_RES_LSB 8
`define ADCPT_WARM_MIN 16'h0010
`define ADCPT_WARM_MIN_CODE 4'h4
`define ADCPT_BASE_BITS 11'h006
`define ADCPT_CONV_EXTRA 2

`endif

//--- include/adcpt_pkg.sv
// Purpose: Types of the converter core power and timing controller
// Assumes: Nothing
// Notes: Constants live in the defines header
package adcpt_pkg;
  typedef enum logic [1:0] {
    ADCPT_IDLE = 2'b00,
    ADCPT_DELAY = 2'b01,
    ADCPT_CONV = 2'b10
  } adcpt_state_e;
endpackage : adcpt_pkg

//--- rtl/adcpt_conv_seq.sv
// Purpose: Trigger, delay and conversion timing of one dedicated core
// Assumes: srcTick is a one-clock pulse per core source clock period
// Notes: Losing ready aborts any conversion
`timescale 1ns/1ps
`include "adcpt_defines.svh"
module adcpt_conv_seq
  import adcpt_pkg::*;
#(
  parameter int CONV_EXTRA = `ADCPT_CONV_EXTRA
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic srcTick,
  adcpt_core_if.seq cif
);
  adcpt_state_e state;
  logic [7:0] divCnt;
  logic [7:0] divLimit;
  logic convTick;
  logic trigPrev;
  logic trigHit;
  logic [10:0] cnt;
  logic [10:0] totalCnt;
  logic [10:0] delayEnd;
  logic [10:0] earlyAt;
  logic [3:0] leadCnt;

  assign divLimit = (cif.source_clock_divider == 7'h00) ? 8'h02 : {cif.source_clock_divider, 1'b0};
  assign convTick = srcTick && (divCnt >= divLimit - 8'h01);
  assign trigHit = cif.trigger && (cif.levelMode || !trigPrev);
  assign totalCnt = `ADCPT_BASE_BITS + {8'h00, cif.bitDepth, 1'b0} + 11'(CONV_EXTRA);
  assign delayEnd = {1'b0, cif.delay} + 11'h001;
  assign earlyAt = totalCnt - 11'h002 - {8'h00, cif.early_irq_lead_select};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      divCnt <= 8'h00;
    else if (srcTick)
      divCnt <= convTick ? 8'h00 : divCnt + 8'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      trigPrev <= 1'b0;
    else
      trigPrev <= cif.trigger;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ADCPT_IDLE;
      cnt <= 11'h000;
    end
    else if (!cif.ready)
    begin
      state <= ADCPT_IDLE;
      cnt <= 11'h000;
    end
    else
    begin
      case (state)
        ADCPT_IDLE:
          if (trigHit)
          begin
            cnt <= 11'h000;
            state <= cif.delayEn ? ADCPT_DELAY : ADCPT_CONV;
          end
        ADCPT_DELAY:
          if (convTick)
          begin
            if (cnt == delayEnd)
            begin
              cnt <= 11'h000;
              state <= ADCPT_CONV;
            end
            else
              cnt <= cnt + 11'h001;
          end
        ADCPT_CONV:
          if (convTick)
          begin
            if (cnt == totalCnt - 11'h001)
            begin
              cnt <= 11'h000;
              state <= ADCPT_IDLE;
            end
            else
              cnt <= cnt + 11'h001;
          end
        default:
          state <= ADCPT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cif.sampling <= 1'b0;
      cif.convStart <= 1'b0;
      cif.dataReady <= 1'b0;
      cif.early <= 1'b0;
    end
    else
    begin
      cif.sampling <= cif.ready && state != ADCPT_CONV;
      cif.convStart <= cif.ready && ((state == ADCPT_IDLE && trigHit && !cif.delayEn) ||
        (state == ADCPT_DELAY && convTick && cnt == delayEnd));
      cif.dataReady <= cif.ready && state == ADCPT_CONV && convTick &&
        cnt == totalCnt - 11'h001;
      cif.early <= cif.ready && state == ADCPT_CONV && convTick && cnt == earlyAt;
    end
  end

  sequence s_delay_done;
    state == ADCPT_DELAY && convTick && cnt == delayEnd && cif.ready;
  endsequence
  property p_delay_len;
    @(posedge clk) disable iff (rst) s_delay_done |=> state == ADCPT_CONV && cif.convStart;
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay end missed");

  sequence s_trig_nodelay;
    cif.ready && state == ADCPT_IDLE && trigHit && !cif.delayEn;
  endsequence
  property p_no_delay;
    @(posedge clk) disable iff (rst) s_trig_nodelay |=> state == ADCPT_CONV && cif.convStart;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("undelayed start missed");

  property p_delay_gate;
    @(posedge clk) disable iff (rst)
      $rose(state == ADCPT_DELAY) |-> $past(cif.delayEn);
  endproperty
  a_delay_gate: assert property (p_delay_gate) else $error("delay without enable");

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      leadCnt <= 4'h0;
    else if (cif.early)
      leadCnt <= 4'h0;
    else if (convTick && leadCnt != 4'hf)
      leadCnt <= leadCnt + 4'h1;
  end

  property p_early_lead;
    @(posedge clk) disable iff (rst)
      cif.dataReady |-> leadCnt == {1'b0, cif.early_irq_lead_select} + 4'h1;
  endproperty
  a_early_lead: assert property (p_early_lead) else $error("early lead wrong");
endmodule : adcpt_conv_seq

//--- rtl/adcpt_ctrl.sv
// Purpose: Converter core power, warm-up, input select and timing control
//          behind an AHB-Lite register slave
// Assumes: Triggers, buffer reads and mode bits come from logic on clk
// Notes: Zero-wait-state slave, always OKAY
`timescale 1ns/1ps
`include "adcpt_defines.svh"
module adcpt_ctrl
  import adcpt_pkg::*;
#(
  parameter int CONV_EXTRA = `ADCPT_CONV_EXTRA
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [1:0] coreTrigger,
  input wire logic [1:0] twoEndedMode,
  input wire logic bufRead,
  input wire logic [3:0] bufReadChan,
  output logic [3:0] core0InputOneHot,
  output logic [3:0] core1InputOneHot,
  output logic [1:0] negInputActive,
  output logic [2:0] corePowerOn,
  output logic [1:0] coreSampling,
  output logic [1:0] coreConvStart,
  output logic [1:0] coreDataReady,
  output logic [14:0] earlyIrqFlag,
  output logic commonIrq,
  output logic earlyIrq
);
  logic wEn;
  logic rdPhase;
  logic [7:0] wAddr;
  logic [7:0] rAddr;
  logic [3:0] inSel;
  logic [2:0] pwr;
  logic [3:0] warmCode;
  logic [2:0] readyIrqEn;
  logic [1:0] delayEn;
  logic [14:0] levelSel;
  logic [14:0] earlyEn;
  logic [5:0] srcDiv;
  logic [5:0] srcCnt;
  logic srcTick;
  logic [9:0] delayVal [2];
  logic [2:0] eiselVal [2];
  logic [1:0] resVal [2];
  logic [6:0] clkDivVal [2];
  logic [2:0] ready;
  logic [2:0] readyRise;
  logic [3:0] earlyChan [2];
  logic [1:0] earlyEvt;
  logic [14:0] earlySet;

  adcpt_core_if cif [2] ();

  // AHB address phase capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wEn <= 1'b0;
      rdPhase <= 1'b0;
      wAddr <= 8'h00;
      rAddr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wEn <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
      rdPhase <= hsel && hready && htrans[1] && !hwrite;
      wAddr <= haddr[7:0];
      rAddr <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata <= rdMux(haddr[7:0]);
    end
  end

  function automatic logic [31:0] rdMux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      `ADCPT_OFF_INSEL: d[3:0] = inSel;
      `ADCPT_OFF_PWR:
      begin
        d[`ADCPT_SHR_PWR_BIT] = pwr[2];
        d[1:0] = pwr[1:0];
        d[`ADCPT_SHR_RDY_BIT] = ready[2] && pwr[2];
        d[`ADCPT_RDY_LSB +: 2] = ready[1:0] & pwr[1:0];
      end
      `ADCPT_OFF_WARM:
      begin
        d[`ADCPT_WARM_LSB +: 4] = warmCode;
        d[`ADCPT_SHR_PWR_BIT] = readyIrqEn[2];
        d[1:0] = readyIrqEn[1:0];
      end
      `ADCPT_OFF_DLY0: d[9:0] = delayVal[0];
      `ADCPT_OFF_DLY0 + `ADCPT_CORE_STRIDE: d[9:0] = delayVal[1];
      `ADCPT_OFF_CLK0: d[15:0] = {3'h0, eiselVal[0], resVal[0], 1'b0, clkDivVal[0]};
      `ADCPT_OFF_CLK0 + `ADCPT_CORE_STRIDE:
        d[15:0] = {3'h0, eiselVal[1], resVal[1], 1'b0, clkDivVal[1]};
      `ADCPT_OFF_DLYEN: d[1:0] = delayEn;
      `ADCPT_OFF_LVL: d[14:0] = levelSel;
      `ADCPT_OFF_EARLY_IRQ_ENABLE: d[14:0] = earlyEn;
      `ADCPT_OFF_EIFLAG: d[14:0] = earlyIrqFlag;
      `ADCPT_OFF_SRCDIV: d[5:0] = srcDiv;
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction : rdMux

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      inSel <= 4'h0;
      pwr <= 3'h0;
      warmCode <= 4'h0;
      readyIrqEn <= 3'h0;
      delayEn <= 2'h0;
      levelSel <= 15'h0000;
      earlyEn <= 15'h0000;
      srcDiv <= 6'h00;
    end
    else if (wEn)
    begin
      case (wAddr)
        `ADCPT_OFF_INSEL: inSel <= hwdata[3:0];
        `ADCPT_OFF_PWR: pwr <= {hwdata[`ADCPT_SHR_PWR_BIT], hwdata[1:0]};
        `ADCPT_OFF_WARM:
        begin
          warmCode <= hwdata[`ADCPT_WARM_LSB +: 4];
          readyIrqEn <= {hwdata[`ADCPT_SHR_PWR_BIT], hwdata[1:0]};
        end
        `ADCPT_OFF_DLYEN: delayEn <= hwdata[1:0];
        `ADCPT_OFF_LVL: levelSel <= hwdata[14:0] & `ADCPT_CHAN_MASK;
        `ADCPT_OFF_EARLY_IRQ_ENABLE: earlyEn <= hwdata[14:0] & `ADCPT_CHAN_MASK;
        `ADCPT_OFF_SRCDIV: srcDiv <= hwdata[5:0];
        default: srcDiv <= srcDiv;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      srcCnt <= 6'h00;
      srcTick <= 1'b0;
    end
    else
    begin
      srcTick <= srcCnt >= srcDiv;
      srcCnt <= (srcCnt >= srcDiv) ? 6'h00 : srcCnt + 6'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_warm
      adcpt_warmup u_warm (
        .clk(clk),
        .rst(rst),
        .srcTick(srcTick),
        .powerOn(pwr[g]),
        .code(warmCode),
        .ready(ready[g]),
        .readyRise(readyRise[g])
      );
    end
    for (g = 0; g < 2; g++)
    begin : g_core
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          delayVal[g] <= 10'h000;
          eiselVal[g] <= 3'h0;
          resVal[g] <= `ADCPT_RES_RESET;
          clkDivVal[g] <= 7'h00;
        end
        else if (wEn && wAddr == `ADCPT_OFF_DLY0 + 8'(g * 8))
          delayVal[g] <= hwdata[9:0];
        else if (wEn && wAddr == `ADCPT_OFF_CLK0 + 8'(g * 8))
        begin
          eiselVal[g] <= hwdata[`ADCPT_EARLY_IRQ_LEAD_SELECT_LSB +: 3];
          resVal[g] <= hwdata[`ADCPT_RES_LSB +: 2];
          clkDivVal[g] <= hwdata[6:0];
        end
      end

      assign cif[g].trigger = coreTrigger[g];
      assign cif[g].ready = ready[g];
      assign cif[g].levelMode = (earlyChan[g] == `ADCPT_NO_CHAN) ? 1'b0 : levelSel[earlyChan[g]];
      assign cif[g].delayEn = delayEn[g];
      assign cif[g].delay = delayVal[g];
      assign cif[g].source_clock_divider = clkDivVal[g];
      assign cif[g].bitDepth = resVal[g];
      assign cif[g].early_irq_lead_select = eiselVal[g];

      adcpt_conv_seq #(
        .CONV_EXTRA(CONV_EXTRA)
      ) u_seq (
        .clk(clk),
        .rst(rst),
        .srcTick(srcTick),
        .cif(cif[g])
      );

      assign earlyChan[g] = (inSel[2 * g +: 2] == 2'h0) ? 4'(g) :
        (inSel[2 * g +: 2] == 2'h1) ? 4'(7 + g) : `ADCPT_NO_CHAN;
      assign earlyEvt[g] = cif[g].early && earlyChan[g] != `ADCPT_NO_CHAN &&
        earlyEn[earlyChan[g]];

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          coreSampling[g] <= 1'b0;
          coreConvStart[g] <= 1'b0;
          coreDataReady[g] <= 1'b0;
        end
        else
        begin
          coreSampling[g] <= cif[g].sampling;
          coreConvStart[g] <= cif[g].convStart;
          coreDataReady[g] <= cif[g].dataReady;
        end
      end
    end
  endgenerate

  always_comb
  begin
    earlySet = 15'h0000;
    for (int c = 0; c < 2; c++)
      if (earlyEvt[c])
        earlySet[earlyChan[c]] = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      earlyIrqFlag <= 15'h0000;
    else
      earlyIrqFlag <= ((earlyIrqFlag & ~((bufRead ? 15'h0001 : 15'h0000) << bufReadChan))
        | earlySet) & `ADCPT_CHAN_MASK;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core0InputOneHot <= 4'h1;
      core1InputOneHot <= 4'h1;
      negInputActive <= 2'h0;
      corePowerOn <= 3'h0;
    end
    else
    begin
      core0InputOneHot <= 4'h1 << inSel[1:0];
      core1InputOneHot <= 4'h1 << inSel[3:2];
      negInputActive <= twoEndedMode;
      corePowerOn <= pwr;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      commonIrq <= 1'b0;
      earlyIrq <= 1'b0;
    end
    else
    begin
      commonIrq <= |(readyRise & readyIrqEn);
      earlyIrq <= |earlyEvt;
    end
  end

  property p_sel0;
    @(posedge clk) disable iff (rst) ##1 core0InputOneHot == 4'h1 << $past(inSel[1:0]);
  endproperty
  a_sel0: assert property (p_sel0) else $error("core 0 routing wrong");

  property p_sel1;
    @(posedge clk) disable iff (rst) ##1 core1InputOneHot == 4'h1 << $past(inSel[3:2]);
  endproperty
  a_sel1: assert property (p_sel1) else $error("core 1 routing wrong");

  property p_rsv;
    @(posedge clk) disable iff (rst)
      rdPhase && rAddr == `ADCPT_OFF_INSEL |-> hrdata[31:4] == 28'h0000000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

  property p_shr_irq;
    @(posedge clk) disable iff (rst) readyRise[2] && readyIrqEn[2] |=> commonIrq;
  endproperty
  a_shr_irq: assert property (p_shr_irq) else $error("shared ready irq missing");

  property p_ded_irq;
    @(posedge clk) disable iff (rst)
      commonIrq |-> $past(readyRise[2] && readyIrqEn[2]) || $past(readyRise[1] && readyIrqEn[1])
        || $past(readyRise[0] && readyIrqEn[0]);
  endproperty
  a_ded_irq: assert property (p_ded_irq) else $error("spurious ready irq");

  property p_set_wins;
    @(posedge clk) disable iff (rst) earlySet != 15'h0000 |=> (earlyIrqFlag & $past(earlySet))
      == $past(earlySet);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("early flag lost");

  property p_power;
    @(posedge clk) disable iff (rst) wEn && wAddr == `ADCPT_OFF_PWR |=>
      pwr == {$past(hwdata[`ADCPT_SHR_PWR_BIT]), $past(hwdata[1:0])} ##1 corePowerOn == $past(pwr);
  endproperty
  a_power: assert property (p_power) else $error("power enable not written");
endmodule : adcpt_ctrl

//--- rtl/adcpt_warmup.sv
// Purpose: Power-up delay and ready flag of one converter core
// Assumes: srcTick is a one-clock pulse per core source clock period
// Notes: Dropping power clears the flag at once
`timescale 1ns/1ps
`include "adcpt_defines.svh"
module adcpt_warmup
  import adcpt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic srcTick,
  input wire logic powerOn,
  input wire logic [3:0] code,
  output logic ready,
  output logic readyRise
);
  logic [15:0] cnt;
  logic [15:0] target;

  assign target = (code <= `ADCPT_WARM_MIN_CODE) ? `ADCPT_WARM_MIN : (16'h0001 << code);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 16'h0000;
      ready <= 1'b0;
      readyRise <= 1'b0;
    end
    else
    begin
      readyRise <= 1'b0;
      if (!powerOn)
      begin
        cnt <= 16'h0000;
        ready <= 1'b0;
      end
      else if (!ready && srcTick)
      begin
        if (cnt == target - 16'h0001)
        begin
          ready <= 1'b1;
          readyRise <= 1'b1;
        end
        else
          cnt <= cnt + 16'h0001;
      end
    end
  end

  property p_off_not_ready;
    @(posedge clk) disable iff (rst) !powerOn |=> !ready;
  endproperty
  a_off_not_ready: assert property (p_off_not_ready) else $error("ready while unpowered");

  property p_warm_count;
    @(posedge clk) disable iff (rst)
      $rose(ready) |-> $past(cnt) == target - 16'h0001 && $past(srcTick);
  endproperty
  a_warm_count: assert property (p_warm_count) else $error("warm-up count wrong");
endmodule : adcpt_warmup
